// [core/dpll_mode_pkg.sv]
package dpll_mode_pkg;

  // Timing base
  localparam longint CLK_HZ = 125_000_000;
  localparam int CNT_W = 34;
  localparam longint LOCK_TIME_MS = 1000;
  localparam longint HOLD_UPD_A_MS = 26;
  localparam longint HOLD_UPD_B_MS = 1000;
  localparam longint HOLD_UPD_C_MS = 10000;
  localparam longint HOLD_UPD_D_MS = 60000;

  // Whole cycles in a time given in milliseconds, rounded down
  function automatic logic [CNT_W-1:0] ms_cycles(input longint ms);
    return CNT_W'(ms * CLK_HZ / 1000);
  endfunction : ms_cycles

  localparam logic [CNT_W-1:0] LOCK_CYC = ms_cycles(LOCK_TIME_MS);
  localparam logic [CNT_W-1:0] HOLD_A_CYC = ms_cycles(HOLD_UPD_A_MS);
  localparam logic [CNT_W-1:0] HOLD_B_CYC = ms_cycles(HOLD_UPD_B_MS);
  localparam logic [CNT_W-1:0] HOLD_C_CYC = ms_cycles(HOLD_UPD_C_MS);
  localparam logic [CNT_W-1:0] HOLD_D_CYC = ms_cycles(HOLD_UPD_D_MS);

  // Reference inputs
  localparam int NUM_REFS = 4;
  localparam int REF_W = 2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL0 = 8'h1d;
  localparam logic [7:0] IDX_MODE_SEL = 8'h1f;
  localparam logic [7:0] IDX_REF_SEL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;

  // Field positions
  localparam int BW_LSB = 0;
  localparam int SLOPE_LSB = 2;
  localparam int HUPD_LSB = 4;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ACQ_BIT = 2;
  localparam int ST_LOCKED_BIT = 3;
  localparam int ST_BW_LSB = 4;
  localparam int ST_REF_LSB = 6;

  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h1c;
  localparam logic [7:0] MODE_SEL_RST = 8'h00;
  localparam logic [7:0] REF_SEL_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_AUTO_NORMAL, MODE_MAN_NORMAL, MODE_MAN_HOLDOVER,
                            MODE_MAN_FREERUN} mode_sel_t;
  typedef enum logic [1:0] {BW_SEL_14, BW_SEL_28, BW_SEL_WIDE, BW_SEL_SPARE} bw_sel_t;
  typedef enum logic [1:0] {BW_14HZ, BW_28HZ, BW_56HZ, BW_890HZ} bw_t;
  typedef enum logic [1:0] {SLOPE_885NS, SLOPE_7US5, SLOPE_61US, SLOPE_UNLIMITED} slope_t;
  typedef enum logic [1:0] {UPD_26MS, UPD_1S, UPD_10S, UPD_60S} upd_t;
  typedef enum logic [1:0] {REF_2KHZ, REF_8KHZ, REF_ABOVE_8KHZ, REF_UNKNOWN} ref_freq_t;
  typedef enum logic [1:0] {OP_FREE_RUN, OP_NORMAL, OP_HOLDOVER, OP_SPARE} op_mode_t;

endpackage : dpll_mode_pkg

// [core/dpll_mode_control.sv]
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
module dpll_mode_control #(
  parameter int FREQ_W = 32,
  parameter logic [dpll_mode_pkg::CNT_W-1:0] LOCK_CYCLES = dpll_mode_pkg::LOCK_CYC,
  parameter logic [dpll_mode_pkg::CNT_W-1:0] HOLD_A_CYCLES = dpll_mode_pkg::HOLD_A_CYC,
  parameter logic [dpll_mode_pkg::CNT_W-1:0] HOLD_B_CYCLES = dpll_mode_pkg::HOLD_B_CYC,
  parameter logic [dpll_mode_pkg::CNT_W-1:0] HOLD_C_CYCLES = dpll_mode_pkg::HOLD_C_CYC,
  parameter logic [dpll_mode_pkg::CNT_W-1:0] HOLD_D_CYCLES = dpll_mode_pkg::HOLD_D_CYC
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [9:0] address, // Byte address
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [31:0] writedata, // Write data
  input wire logic [3:0] byteenable, // Byte lanes
  output logic [31:0] readdata, // Read data
  output logic waitrequest, // Stall
  output logic [1:0] response, // Access status
  input wire logic [dpll_mode_pkg::NUM_REFS-1:0] ref_qualified, // Monitor qualified
  input wire logic [dpll_mode_pkg::NUM_REFS-1:0] ref_fail, // Monitor failure
  input wire logic [1:0] ref_freq_class, // Selected reference rate class
  input wire logic [FREQ_W-1:0] loop_freq, // Loop filter frequency word
  output logic [1:0] op_mode, // Reported operating mode
  output logic acquiring, // Lock acquisition running
  output logic [dpll_mode_pkg::REF_W-1:0] selected_ref, // Reference in use
  output logic ref_switch, // Switch-over pulse
  output logic [FREQ_W-1:0] dco_freq, // Frequency word to oscillator
  output logic hist_update, // History update pulse
  output logic [1:0] eff_bandwidth, // Effective loop bandwidth
  output logic [1:0] slope_limit // Phase slope limit
);

  typedef enum logic [1:0] {ST_FREE_RUN, ST_ACQUIRE, ST_NORMAL, ST_HOLDOVER} ctl_state_t;

  localparam int RW = dpll_mode_pkg::REF_W;
  localparam int CW = dpll_mode_pkg::CNT_W;

  logic [7:0] loop_control_zero;
  logic [7:0] loop_mode_select;
  logic [7:0] loop_reference_select;
  ctl_state_t state;
  ctl_state_t next_state;
  logic [RW-1:0] next_ref;
  logic locked_ever;
  logic hist_valid;
  logic [CW-1:0] acq_cnt;
  logic [CW-1:0] upd_cnt;
  logic [FREQ_W-1:0] hist_freq;

  // Lowest index wins: {found, index}
  function automatic logic [RW:0] first_good(input logic [dpll_mode_pkg::NUM_REFS-1:0] g);
    logic [RW:0] r;
    r = '0;
    for (int i = dpll_mode_pkg::NUM_REFS - 1; i >= 0; i--) begin
      if (g[i]) begin
        r = {1'b1, RW'(i)};
      end
    end
    return r;
  endfunction : first_good

  function automatic dpll_mode_pkg::bw_t eff_bw(input dpll_mode_pkg::bw_sel_t s,
                                                input dpll_mode_pkg::ref_freq_t f);
    unique case (s)
      dpll_mode_pkg::BW_SEL_28: begin
        return (f == dpll_mode_pkg::REF_2KHZ) ? dpll_mode_pkg::BW_14HZ : dpll_mode_pkg::BW_28HZ;
      end
      dpll_mode_pkg::BW_SEL_WIDE: begin
        unique case (f)
          dpll_mode_pkg::REF_ABOVE_8KHZ: return dpll_mode_pkg::BW_890HZ;
          dpll_mode_pkg::REF_8KHZ: return dpll_mode_pkg::BW_56HZ;
          default: return dpll_mode_pkg::BW_14HZ;
        endcase
      end
      default: return dpll_mode_pkg::BW_14HZ;
    endcase
  endfunction : eff_bw

  function automatic logic [CW-1:0] hold_period(input dpll_mode_pkg::upd_t u);
    unique case (u)
      dpll_mode_pkg::UPD_26MS: return HOLD_A_CYCLES;
      dpll_mode_pkg::UPD_1S: return HOLD_B_CYCLES;
      dpll_mode_pkg::UPD_10S: return HOLD_C_CYCLES;
      dpll_mode_pkg::UPD_60S: return HOLD_D_CYCLES;
    endcase
  endfunction : hold_period

  // Reference evaluation
  logic [dpll_mode_pkg::NUM_REFS-1:0] good;
  logic [RW:0] best_pick;
  logic any_good;
  logic [RW-1:0] best;
  logic [RW-1:0] man_ref;
  dpll_mode_pkg::mode_sel_t mode;
  ctl_state_t fallback;
  dpll_mode_pkg::upd_t upd_sel;
  logic upd_tick;

  assign good = ref_qualified & ~ref_fail;
  assign best_pick = first_good(good);
  assign any_good = best_pick[RW];
  assign best = best_pick[RW-1:0];
  assign man_ref = loop_reference_select[RW-1:0];
  assign mode = dpll_mode_pkg::mode_sel_t'(loop_mode_select[1:0]);
  assign fallback = locked_ever ? ST_HOLDOVER : ST_FREE_RUN;
  assign upd_sel = dpll_mode_pkg::upd_t'(loop_control_zero[dpll_mode_pkg::HUPD_LSB +: 2]);
  assign upd_tick = upd_cnt >= hold_period(upd_sel) - CW'(1);

  always_comb begin
    next_state = state;
    next_ref = selected_ref;
    unique case (mode)
      dpll_mode_pkg::MODE_MAN_FREERUN: next_state = ST_FREE_RUN;
      dpll_mode_pkg::MODE_MAN_HOLDOVER: next_state = ST_HOLDOVER;
      dpll_mode_pkg::MODE_MAN_NORMAL: begin
        unique case (state)
          ST_FREE_RUN, ST_HOLDOVER: begin
            if (good[man_ref]) begin
              next_state = ST_ACQUIRE;
              next_ref = man_ref;
            end
          end
          ST_ACQUIRE, ST_NORMAL: begin
            if (!good[man_ref]) begin
              next_state = ST_HOLDOVER;
            end else if (man_ref != selected_ref) begin
              next_state = ST_ACQUIRE;
              next_ref = man_ref;
            end else if (state == ST_ACQUIRE && acq_cnt >= LOCK_CYCLES - CW'(1)) begin
              next_state = ST_NORMAL;
            end
          end
        endcase
      end
      dpll_mode_pkg::MODE_AUTO_NORMAL: begin
        unique case (state)
          ST_FREE_RUN, ST_HOLDOVER: begin
            if (any_good) begin
              next_state = ST_ACQUIRE;
              next_ref = best;
            end
          end
          ST_ACQUIRE: begin
            if (!any_good) begin
              next_state = fallback;
            end else if (!good[selected_ref]) begin
              next_ref = best;
            end else if (acq_cnt >= LOCK_CYCLES - CW'(1)) begin
              next_state = ST_NORMAL;
            end
          end
          ST_NORMAL: begin
            if (!any_good) begin
              next_state = ST_HOLDOVER;
            end else if (best != selected_ref) begin
              next_ref = best;
            end
          end
        endcase
      end
    endcase
  end

  // Mode state and selected reference
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_FREE_RUN;
      selected_ref <= '0;
      ref_switch <= 1'b0;
    end else begin
      state <= next_state;
      selected_ref <= next_ref;
      ref_switch <= state == ST_NORMAL && next_state == ST_NORMAL && next_ref != selected_ref;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      locked_ever <= 1'b0;
    end else if (next_state == ST_NORMAL) begin
      locked_ever <= 1'b1;
    end
  end

  // Acquisition timer restarts whenever the target changes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acq_cnt <= '0;
    end else if (state == ST_ACQUIRE && next_state == ST_ACQUIRE && next_ref == selected_ref) begin
      acq_cnt <= acq_cnt + CW'(1);
    end else begin
      acq_cnt <= '0;
    end
  end

  // History averages locked frequency; frozen outside normal
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upd_cnt <= '0;
      hist_freq <= '0;
      hist_valid <= 1'b0;
      hist_update <= 1'b0;
    end else begin
      hist_update <= 1'b0;
      if (state != ST_NORMAL || upd_tick) begin
        upd_cnt <= '0;
      end else begin
        upd_cnt <= upd_cnt + CW'(1);
      end
      if (state == ST_NORMAL && upd_tick) begin
        hist_update <= 1'b1;
        hist_valid <= 1'b1;
        hist_freq <= hist_valid ?
          FREQ_W'(({1'b0, hist_freq} + {1'b0, loop_freq}) >> 1) : loop_freq;
      end
    end
  end

  // Outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dco_freq <= '0;
      op_mode <= dpll_mode_pkg::OP_FREE_RUN;
      acquiring <= 1'b0;
    end else begin
      acquiring <= state == ST_ACQUIRE;
      unique case (state)
        ST_FREE_RUN: begin
          dco_freq <= '0;
          op_mode <= dpll_mode_pkg::OP_FREE_RUN;
        end
        ST_ACQUIRE: begin
          dco_freq <= loop_freq;
          op_mode <= locked_ever ? dpll_mode_pkg::OP_HOLDOVER : dpll_mode_pkg::OP_FREE_RUN;
        end
        ST_NORMAL: begin
          dco_freq <= loop_freq;
          op_mode <= dpll_mode_pkg::OP_NORMAL;
        end
        ST_HOLDOVER: begin
          dco_freq <= hist_freq;
          op_mode <= dpll_mode_pkg::OP_HOLDOVER;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eff_bandwidth <= dpll_mode_pkg::BW_14HZ;
      slope_limit <= dpll_mode_pkg::SLOPE_UNLIMITED;
    end else begin
      eff_bandwidth <= eff_bw(dpll_mode_pkg::bw_sel_t'(loop_control_zero[dpll_mode_pkg::BW_LSB +: 2]),
                              dpll_mode_pkg::ref_freq_t'(ref_freq_class));
      slope_limit <= loop_control_zero[dpll_mode_pkg::SLOPE_LSB +: 2];
    end
  end

  // Avalon slave: one wait cycle, then answer
  logic [7:0] idx;
  logic req;
  logic take;
  logic mapped;
  logic [7:0] status;

  assign idx = address[9:2];
  assign req = read | write;
  assign take = write & ~waitrequest & byteenable[0];
  assign mapped = idx == dpll_mode_pkg::IDX_CTRL0 || idx == dpll_mode_pkg::IDX_MODE_SEL ||
                  idx == dpll_mode_pkg::IDX_REF_SEL || idx == dpll_mode_pkg::IDX_STATUS;
  assign status = {selected_ref, eff_bandwidth, locked_ever, acquiring, op_mode};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata <= '0;
      response <= dpll_mode_pkg::RESP_OKAY;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (req & waitrequest) begin
        response <= mapped ? dpll_mode_pkg::RESP_OKAY : dpll_mode_pkg::RESP_SLVERR;
        readdata <= '0;
        if (read) begin
          unique case (idx)
            dpll_mode_pkg::IDX_CTRL0: readdata[7:0] <= loop_control_zero;
            dpll_mode_pkg::IDX_MODE_SEL: readdata[7:0] <= loop_mode_select;
            dpll_mode_pkg::IDX_REF_SEL: readdata[7:0] <= loop_reference_select;
            dpll_mode_pkg::IDX_STATUS: readdata[7:0] <= status;
            default: readdata <= '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loop_control_zero <= dpll_mode_pkg::CTRL0_RST;
      loop_mode_select <= dpll_mode_pkg::MODE_SEL_RST;
      loop_reference_select <= dpll_mode_pkg::REF_SEL_RST;
    end else if (take) begin
      if (idx == dpll_mode_pkg::IDX_CTRL0) begin
        loop_control_zero <= {2'h0, writedata[5:0]};
      end
      if (idx == dpll_mode_pkg::IDX_MODE_SEL) begin
        loop_mode_select <= {6'h00, writedata[1:0]};
      end
      if (idx == dpll_mode_pkg::IDX_REF_SEL) begin
        loop_reference_select <= {{(8 - RW){1'b0}}, writedata[RW-1:0]};
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_mode_auto: assert property ($past(sys_rst) |-> loop_mode_select == 8'h00 &&
    state == ST_FREE_RUN) else $error("mode select or state wrong after reset");
  a_reset_slope_free: assert property ($past(sys_rst) |=>
    slope_limit == dpll_mode_pkg::SLOPE_UNLIMITED) else $error("slope limit not unlimited");
  a_forced_freerun: assert property (mode == dpll_mode_pkg::MODE_MAN_FREERUN |=>
    state == ST_FREE_RUN ##1 dco_freq == '0) else $error("manual free-run not kept");
  a_forced_holdover: assert property (mode == dpll_mode_pkg::MODE_MAN_HOLDOVER |=>
    state == ST_HOLDOVER) else $error("manual holdover not kept");
  a_manual_fail_hold: assert property (mode == dpll_mode_pkg::MODE_MAN_NORMAL &&
    state == ST_NORMAL && !good[man_ref] |=> state == ST_HOLDOVER)
    else $error("manual normal did not fall to holdover");
  a_auto_switch_over: assert property (mode == dpll_mode_pkg::MODE_AUTO_NORMAL &&
    state == ST_NORMAL && !good[selected_ref] && any_good |=>
    state == ST_NORMAL && selected_ref == $past(best) && ref_switch)
    else $error("switch-over to next reference missing");
  a_auto_lost_ref: assert property (mode == dpll_mode_pkg::MODE_AUTO_NORMAL &&
    state == ST_NORMAL && !any_good |=> state == ST_HOLDOVER ##1 op_mode == 2'h2)
    else $error("normal without reference did not enter holdover");
  a_never_locked_free: assert property (mode == dpll_mode_pkg::MODE_AUTO_NORMAL &&
    !locked_ever && !any_good && state != ST_NORMAL |=> state == ST_FREE_RUN)
    else $error("left free-run without a lock");
  a_start_acquire: assert property (mode == dpll_mode_pkg::MODE_AUTO_NORMAL &&
    state == ST_FREE_RUN && any_good |=> state == ST_ACQUIRE ##1 acquiring)
    else $error("acquisition not started");
  a_acquire_time: assert property (state == ST_ACQUIRE && next_state == ST_NORMAL |->
    acq_cnt == LOCK_CYCLES - CW'(1)) else $error("lock declared at wrong time");
  a_holdover_word: assert property (state == ST_HOLDOVER |=>
    dco_freq == $past(hist_freq)) else $error("holdover word not from history");
  a_bw_limit_2k: assert property (loop_control_zero[1:0] == 2'h1 && ref_freq_class == 2'h0
    |=> eff_bandwidth == dpll_mode_pkg::BW_14HZ) else $error("28 Hz not limited at 2 kHz");
  a_bw_wide_890: assert property (loop_control_zero[1:0] == 2'h2 && ref_freq_class == 2'h2
    |=> eff_bandwidth == dpll_mode_pkg::BW_890HZ) else $error("wideband not 890 Hz");
  a_bus_answer: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

  c_lock_reached: cover property (state == ST_ACQUIRE ##1 state == ST_NORMAL);
  c_enter_holdover: cover property (state == ST_NORMAL ##1 state == ST_HOLDOVER);
  c_switch_over: cover property (ref_switch);
  c_history_update: cover property (hist_update ##1 state == ST_NORMAL);

endmodule : dpll_mode_control

// [verif/ref_monitor_model.sv]
`timescale 1ns/1ps
module ref_monitor_model (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [3:0] good_cmd, // Inputs presented as healthy
  input wire logic [3:0] fail_cmd, // Inputs presented as broken
  input wire logic [1:0] class_cmd, // Rate class of the inputs
  input wire logic [31:0] freq_cmd, // Loop filter word to present
  output logic [3:0] ref_qualified, // Qualified levels
  output logic [3:0] ref_fail, // Failure levels
  output logic [1:0] ref_freq_class, // Rate class
  output logic [31:0] loop_freq // Loop filter word
);
  // Verdicts lag the line by a cycle; a broken input also loses its qualification
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_qualified <= 4'h0;
      ref_fail <= 4'h0;
    end else begin
      ref_qualified <= good_cmd & ~fail_cmd;
      ref_fail <= fail_cmd;
    end
  end

  always_ff @(posedge clk) begin
    ref_freq_class <= class_cmd;
    loop_freq <= freq_cmd;
  end
endmodule : ref_monitor_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int LOCK_N = 20;
  localparam logic [31:0] WORD_A = 32'h1234_5678;
  localparam logic [31:0] WORD_B = 32'h0abc_def0;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic [3:0] ref_qualified;
  logic [3:0] ref_fail;
  logic [1:0] ref_freq_class;
  logic [31:0] loop_freq;
  logic [31:0] dco_freq;
  logic [1:0] op_mode;
  logic [1:0] eff_bandwidth;
  logic [1:0] slope_limit;
  logic [1:0] selected_ref;
  logic acquiring;
  logic ref_switch;
  logic hist_update;
  logic [3:0] good_cmd = 4'h0;
  logic [3:0] fail_cmd = 4'h0;
  logic [1:0] class_cmd = 2'h2;
  logic [31:0] freq_cmd = WORD_A;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  dpll_mode_control #(.LOCK_CYCLES(34'h14), .HOLD_A_CYCLES(34'h5),
    .HOLD_B_CYCLES(34'h8), .HOLD_C_CYCLES(34'hc), .HOLD_D_CYCLES(34'h10)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .ref_qualified(ref_qualified),
    .ref_fail(ref_fail), .ref_freq_class(ref_freq_class), .loop_freq(loop_freq),
    .op_mode(op_mode), .acquiring(acquiring), .selected_ref(selected_ref),
    .ref_switch(ref_switch), .dco_freq(dco_freq), .hist_update(hist_update),
    .eff_bandwidth(eff_bandwidth), .slope_limit(slope_limit));

  ref_monitor_model u_far (.clk(clk), .sys_rst(sys_rst), .good_cmd(good_cmd),
    .fail_cmd(fail_cmd), .class_cmd(class_cmd), .freq_cmd(freq_cmd),
    .ref_qualified(ref_qualified), .ref_fail(ref_fail),
    .ref_freq_class(ref_freq_class), .loop_freq(loop_freq));

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request holds until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q, output logic [1:0] rsp);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    rsp = response;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0] rsp;
    bus(1'b1, idx, d, 4'hf, q, rsp);
  endtask : wr_reg

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] rsp;
    bus(1'b0, idx, 8'h00, 4'hf, q, rsp);
    check(q, {24'h0, exp});
    check(rsp, er);
  endtask : rd_check

  task automatic wait_mode(input logic [1:0] m, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (op_mode !== m && n < 100);
    check(op_mode, m);
  endtask : wait_mode

  task automatic wait_switch();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ref_switch !== 1'b1 && n < 50);
    check(ref_switch, 1'b1);
  endtask : wait_switch

  task automatic t_reset();
    rd_check(dpll_mode_pkg::IDX_CTRL0, dpll_mode_pkg::CTRL0_RST, 2'h0);
    rd_check(dpll_mode_pkg::IDX_MODE_SEL, 8'h00, 2'h0);
    rd_check(8'h30, 8'h00, dpll_mode_pkg::RESP_SLVERR);
    check(op_mode, dpll_mode_pkg::OP_FREE_RUN);
    check(slope_limit, dpll_mode_pkg::SLOPE_UNLIMITED);
  endtask : t_reset

  task automatic t_lock();
    int n;
    good_cmd <= 4'b0100;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (acquiring !== 1'b1 && n < 10);
    check(acquiring, 1'b1);
    check(selected_ref, 2'h2);
    check(op_mode, dpll_mode_pkg::OP_FREE_RUN);
    wait_mode(dpll_mode_pkg::OP_NORMAL, n);
    check(n >= LOCK_N - 2 && n <= LOCK_N + 2, 1'b1);
    @(posedge clk);
    check(dco_freq, WORD_A);
    rd_check(dpll_mode_pkg::IDX_STATUS, 8'h89, 2'h0);
  endtask : t_lock

  task automatic t_bw();
    logic [1:0] e;
    logic [31:0] q;
    logic [1:0] rsp;
    for (int b = 0; b < 4; b++) begin
      for (int c = 0; c < 4; c++) begin
        wr_reg(dpll_mode_pkg::IDX_CTRL0, {6'h07, b[1:0]});
        class_cmd <= c[1:0];
        repeat (4) @(posedge clk);
        e = 2'h0;
        if (b == 1 && c != 0) e = 2'h1;
        if (b == 2 && c == 1) e = 2'h2;
        if (b == 2 && c == 2) e = 2'h3;
        check(eff_bandwidth, e);
      end
    end
    class_cmd <= 2'h2;
    for (int s = 0; s < 4; s++) begin
      wr_reg(dpll_mode_pkg::IDX_CTRL0, {4'h1, s[1:0], 2'b00});
      repeat (2) @(posedge clk);
      check(slope_limit, s[1:0]);
      rd_check(dpll_mode_pkg::IDX_CTRL0, {4'h1, s[1:0], 2'b00}, 2'h0);
    end
    bus(1'b1, dpll_mode_pkg::IDX_CTRL0, 8'h3f, 4'he, q, rsp);
    rd_check(dpll_mode_pkg::IDX_CTRL0, 8'h1c, 2'h0);
  endtask : t_bw

  task automatic t_switch();
    good_cmd <= 4'b0110;
    wait_switch();
    check(selected_ref, 2'h1);
    check(op_mode, dpll_mode_pkg::OP_NORMAL);
    fail_cmd <= 4'b0010;
    wait_switch();
    check(selected_ref, 2'h2);
    good_cmd <= 4'b0100;
    fail_cmd <= 4'b0000;
    repeat (4) @(posedge clk);
  endtask : t_switch

  task automatic t_hold();
    int n;
    wr_reg(dpll_mode_pkg::IDX_CTRL0, 8'h0c);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (hist_update === 1'b1) n++;
    end
    check(n >= 7 && n <= 8, 1'b1);
    wr_reg(dpll_mode_pkg::IDX_CTRL0, 8'h3c);
    do @(posedge clk); while (hist_update !== 1'b1 && cycles < 4990);
    good_cmd <= 4'b0000;
    freq_cmd <= WORD_B;
    wait_mode(dpll_mode_pkg::OP_HOLDOVER, n);
    repeat (2) @(posedge clk);
    check(dco_freq, WORD_A);
    good_cmd <= 4'b0001;
    do @(posedge clk); while (acquiring !== 1'b1 && cycles < 4990);
    check(op_mode, dpll_mode_pkg::OP_HOLDOVER);
    wait_mode(dpll_mode_pkg::OP_NORMAL, n);
    check(selected_ref, 2'h0);
    @(posedge clk);
    check(dco_freq, WORD_B);
  endtask : t_hold

  task automatic t_manual();
    int n;
    wr_reg(dpll_mode_pkg::IDX_MODE_SEL, 8'h03);
    wait_mode(dpll_mode_pkg::OP_FREE_RUN, n);
    repeat (30) @(posedge clk);
    check(op_mode, dpll_mode_pkg::OP_FREE_RUN);
    check(dco_freq, 32'h0);
    rd_check(dpll_mode_pkg::IDX_MODE_SEL, 8'h03, 2'h0);
    wr_reg(dpll_mode_pkg::IDX_MODE_SEL, 8'h02);
    wait_mode(dpll_mode_pkg::OP_HOLDOVER, n);
    repeat (30) @(posedge clk);
    check({acquiring, op_mode}, {1'b0, dpll_mode_pkg::OP_HOLDOVER});
    wr_reg(dpll_mode_pkg::IDX_REF_SEL, 8'h03);
    good_cmd <= 4'b1001;
    wr_reg(dpll_mode_pkg::IDX_MODE_SEL, 8'h01);
    wait_mode(dpll_mode_pkg::OP_NORMAL, n);
    check(selected_ref, 2'h3);
    fail_cmd <= 4'b1000;
    wait_mode(dpll_mode_pkg::OP_HOLDOVER, n);
    repeat (30) @(posedge clk);
    check(op_mode, dpll_mode_pkg::OP_HOLDOVER);
  endtask : t_manual

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_lock();
    t_bw();
    t_switch();
    t_hold();
    t_manual();
    tally_and_finish();
  end
endmodule : tb
